// ---- verilog/irq_gate_top.sv ----
`timescale 1ns/1ps
module irq_gate_top #(
  parameter int ADDR_W = 5
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic [ADDR_W-1:0]       address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  input  wire logic                    ext_irq_pin_a_n,
  input  wire logic                    ext_irq_pin_b_n,
  input  wire logic                    timer_a_overflow,
  input  wire logic                    timer_b_overflow,
  input  wire logic                    serial_req,
  input  wire irq_gate_pkg::core_ack_t core_ack,
  output logic [4:0]                   irq_request,
  output logic                         irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 5) begin : g_bad_addr
    $error("irq_gate_top: address must reach every register");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  irq_gate_pkg::gate_state_t st;
  irq_gate_pkg::gate_state_t next_st;
  logic [3:0]                phase;
  logic                      s5p2;
  logic [4:0]                ev;
  logic [4:0]                clr;
  logic [4:0]                presented;
  logic [4:0]                addr5;
  logic                      wr;
  logic                      hit;
  logic                      tmr_a_due;
  logic                      tmr_b_due;
  logic [7:0]                wbits;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_mux(
    input logic [4:0]                a,
    input irq_gate_pkg::gate_state_t s,
    input logic [3:0]                ph
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      irq_gate_pkg::OFF_ENABLE:  d[7:0] = s.enable;
      irq_gate_pkg::OFF_EN_SET:  d[7:0] = s.enable;
      irq_gate_pkg::OFF_EN_CLR:  d[7:0] = s.enable;
      irq_gate_pkg::OFF_STATUS:  d[4:0] = s.pend;
      irq_gate_pkg::OFF_MASK:    d[4:0] = s.mask;
      irq_gate_pkg::OFF_REQUEST: d[4:0] = s.request;
      irq_gate_pkg::OFF_PHASE:   d[3:0] = ph;
      default:                   d      = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Machine cycle phases
  // ----------------------------------------------------------------
  machine_phase #(
    .PHASE_COUNT (irq_gate_pkg::PHASES)
  ) u_phase (
    .mclk  (mclk),
    .rst   (rst),
    .phase (phase),
    .s5p2  (s5p2)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    addr5   = address[4:0];

    // Pin synchronisers and edge memory
    next_st.sync_a   = {st.sync_a[0], ext_irq_pin_a_n};
    next_st.sync_b   = {st.sync_b[0], ext_irq_pin_b_n};
    next_st.pin_a_q  = st.sync_a[1];
    next_st.pin_b_q  = st.sync_b[1];
    next_st.serial_q = serial_req;

    // Bus handshake: one wait cycle, then the answer
    hit          = (read | write) & ~st.ack;
    next_st.ack  = hit;
    wr           = write & st.ack;
    wbits        = writedata[7:0] & irq_gate_pkg::ENABLE_IMPL;
    if (hit && read) begin
      next_st.rdata = read_mux(addr5, st, phase);
    end

    // Timer overflows wait for S5P2 of their machine cycle
    tmr_a_due = st.ovf_hold[0] | timer_a_overflow;
    tmr_b_due = st.ovf_hold[1] | timer_b_overflow;
    next_st.ovf_hold[0] = tmr_a_due & ~s5p2;
    next_st.ovf_hold[1] = tmr_b_due & ~s5p2;

    // Source events
    ev = 5'h00;
    ev[irq_gate_pkg::BIT_EXT_PIN_A] = st.pin_a_q & ~st.sync_a[1];
    ev[irq_gate_pkg::BIT_EXT_PIN_B] = st.pin_b_q & ~st.sync_b[1];
    ev[irq_gate_pkg::BIT_TIMER_A]   = tmr_a_due & s5p2;
    ev[irq_gate_pkg::BIT_TIMER_B]   = tmr_b_due & s5p2;
    ev[irq_gate_pkg::BIT_SERIAL]    = serial_req & ~st.serial_q;

    // Clears from software and from the core; a new event wins
    clr = 5'h00;
    if (wr && addr5 == irq_gate_pkg::OFF_STATUS) begin
      clr = writedata[4:0];
    end
    if (core_ack.valid) begin
      clr = clr | core_ack.src;
    end
    next_st.pend = (st.pend & ~clr) | ev;

    // Enable and mask register writes
    if (wr) begin
      unique case (addr5)
        irq_gate_pkg::OFF_ENABLE: begin
          next_st.enable = wbits;
        end
        irq_gate_pkg::OFF_EN_SET: begin
          next_st.enable = st.enable | wbits;
        end
        irq_gate_pkg::OFF_EN_CLR: begin
          next_st.enable = st.enable & ~wbits;
        end
        irq_gate_pkg::OFF_MASK: begin
          next_st.mask = writedata[4:0];
        end
        default: begin
          next_st.enable = st.enable;
        end
      endcase
    end

    // Requests presented to the core, sampled once per machine cycle
    presented = st.pend & st.enable[4:0]
              & {5{st.enable[irq_gate_pkg::BIT_GLOBAL]}};
    if (s5p2) begin
      next_st.request = presented;
    end

    // Software interrupt line
    next_st.irq = |(next_st.pend & next_st.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.sync_a   <= 2'h3;
      st.sync_b   <= 2'h3;
      st.pin_a_q  <= 1'b1;
      st.pin_b_q  <= 1'b1;
      st.enable   <= irq_gate_pkg::ENABLE_RESET;
      st.pend     <= irq_gate_pkg::STATUS_RESET;
      st.mask     <= irq_gate_pkg::MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waitrequest = (read | write) & ~st.ack;
  assign readdata    = st.rdata;
  assign irq_request = st.request;
  assign irq         = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pin_a_event: assert property (
    @(posedge mclk) disable iff (rst)
    (st.pin_a_q && !st.sync_a[1])
      |=> st.pend[irq_gate_pkg::BIT_EXT_PIN_A])
    else $error("pin a fall did not set its pending flag");

  a_serial_event: assert property (
    @(posedge mclk) disable iff (rst)
    (serial_req && !st.serial_q) |=> st.pend[irq_gate_pkg::BIT_SERIAL])
    else $error("serial request did not set its pending flag");

  a_enable_blocks: assert property (
    @(posedge mclk) disable iff (rst)
    s5p2 |=> (irq_request & ~$past(st.enable[4:0])) == 5'h00)
    else $error("disabled source reached the core");

  a_global_gate: assert property (
    @(posedge mclk) disable iff (rst)
    (s5p2 && !st.enable[irq_gate_pkg::BIT_GLOBAL])
      |=> (irq_request == 5'h00) [*3])
    else $error("request presented with the global gate closed");

  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (rst)
    st.enable[irq_gate_pkg::BIT_RSVD_HI:irq_gate_pkg::BIT_RSVD_LO] == 2'h0)
    else $error("reserved enable bits hold a one");

  a_serial_bit: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && addr5 == irq_gate_pkg::OFF_ENABLE)
      |=> st.enable[irq_gate_pkg::BIT_SERIAL] == $past(writedata[4])
       && st.enable[irq_gate_pkg::BIT_TIMER_B] == $past(writedata[3]))
    else $error("serial or timer b enable not at its bit");

  a_low_bits: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && addr5 == irq_gate_pkg::OFF_ENABLE)
      |=> st.enable[2:0] == $past(writedata[2:0]))
    else $error("pin or timer a enable not at its bit");

  a_timer_phase: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(st.pend[irq_gate_pkg::BIT_TIMER_A]) |-> $past(s5p2))
    else $error("timer a flag set away from S5P2");

  a_timer_wait: assert property (
    @(posedge mclk) disable iff (rst)
    (timer_b_overflow && !core_ack.valid && !wr)
      |-> ##[1:12] st.pend[irq_gate_pkg::BIT_TIMER_B])
    else $error("timer b overflow not flagged within a machine cycle");

  a_set_alone: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && addr5 == irq_gate_pkg::OFF_EN_SET)
      |=> st.enable == ($past(st.enable)
          | ($past(writedata[7:0]) & irq_gate_pkg::ENABLE_IMPL)))
    else $error("enable set touched other sources");

  a_clear_alone: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && addr5 == irq_gate_pkg::OFF_EN_CLR)
      |=> st.enable == ($past(st.enable)
          & ~($past(writedata[7:0]) & irq_gate_pkg::ENABLE_IMPL)))
    else $error("enable clear touched other sources");

  a_request_form: assert property (
    @(posedge mclk) disable iff (rst)
    s5p2 |=> irq_request == ($past(st.pend) & $past(st.enable[4:0])
           & {5{$past(st.enable[irq_gate_pkg::BIT_GLOBAL])}}))
    else $error("presented request differs from gated pending flags");

  a_bus_answer: assert property (
    @(posedge mclk) disable iff (rst)
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus answer later than one wait cycle");

  a_irq_line: assert property (
    @(posedge mclk) disable iff (rst)
    irq == |(st.pend & st.mask))
    else $error("interrupt line disagrees with status and mask");

  a_pin_b_event: assert property (
    @(posedge mclk) disable iff (rst)
    (st.pin_b_q && !st.sync_b[1])
      |=> st.pend[irq_gate_pkg::BIT_EXT_PIN_B])
    else $error("pin b fall did not set its pending flag");

  a_timer_b_phase: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(st.pend[irq_gate_pkg::BIT_TIMER_B]) |-> $past(s5p2))
    else $error("timer b flag set away from S5P2");

  a_timer_a_wait: assert property (
    @(posedge mclk) disable iff (rst)
    (timer_a_overflow && !core_ack.valid && !wr)
      |-> ##[1:12] st.pend[irq_gate_pkg::BIT_TIMER_A])
    else $error("timer a overflow not flagged within a machine cycle");

  a_ack_clears: assert property (
    @(posedge mclk) disable iff (rst)
    core_ack.valid
      |=> (st.pend & $past(core_ack.src) & ~$past(ev)) == 5'h00)
    else $error("core acknowledge left its pending flag set");

  a_status_clear: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && addr5 == irq_gate_pkg::OFF_STATUS)
      |=> (st.pend & $past(writedata[4:0]) & ~$past(ev)) == 5'h00)
    else $error("status write of one left its flag set");

  a_request_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !s5p2 |=> $stable(irq_request))
    else $error("presented request changed between polls");

  a_mask_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && addr5 == irq_gate_pkg::OFF_MASK)
      |=> st.mask == $past(writedata[4:0]))
    else $error("mask register did not take the written value");

endmodule

// ---- verilog/irq_gate_pkg.sv ----
// Summary of operation
// - Five sources: two pins, two timers, serial.
// - Each source has its own enable bit.
// - Bit seven gates irq_request globally, not irq.
// - Bit four serial, bit three timer b.
// - Bit two pin b, one timer a, zero pin a.
// - Timer flags set at S5P2, polled next cycle.
// - Changing one enable leaves others untouched.
package irq_gate_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_ENABLE  = 5'h00;
  localparam logic [4:0] OFF_STATUS  = 5'h04;
  localparam logic [4:0] OFF_MASK    = 5'h08;
  localparam logic [4:0] OFF_REQUEST = 5'h0c;
  localparam logic [4:0] OFF_PHASE   = 5'h10;
  localparam logic [4:0] OFF_EN_SET  = 5'h14;
  localparam logic [4:0] OFF_EN_CLR  = 5'h18;

  // ----------------------------------------------------------------
  // Enable register fields
  // ----------------------------------------------------------------
  localparam int SRC_COUNT       = 5;
  localparam int BIT_EXT_PIN_A   = 0;
  localparam int BIT_TIMER_A     = 1;
  localparam int BIT_EXT_PIN_B   = 2;
  localparam int BIT_TIMER_B     = 3;
  localparam int BIT_SERIAL      = 4;
  localparam int BIT_RSVD_LO     = 5;
  localparam int BIT_RSVD_HI     = 6;
  localparam int BIT_GLOBAL      = 7;
  localparam logic [7:0] ENABLE_IMPL  = 8'h9f;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [4:0] MASK_RESET   = 5'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------------
  localparam int         PHASES     = 12;
  localparam logic [3:0] PHASE_S5P2 = 4'h9;
  localparam logic [3:0] PHASE_LAST = 4'hb;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [4:0] src;
  } core_ack_t;

  typedef struct packed {
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic        pin_a_q;
    logic        pin_b_q;
    logic        serial_q;
    logic [1:0]  ovf_hold;
    logic [7:0]  enable;
    logic [4:0]  pend;
    logic [4:0]  mask;
    logic [4:0]  request;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } gate_state_t;

  typedef struct packed {
    logic [3:0] phase;
    logic       s5p2;
  } phase_state_t;

endpackage

// ---- verilog/machine_phase.sv ----
`timescale 1ns/1ps
module machine_phase #(
  parameter int PHASE_COUNT = irq_gate_pkg::PHASES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  output logic [3:0]      phase,
  output logic            s5p2
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (PHASE_COUNT != irq_gate_pkg::PHASES) begin : g_bad_count
    $error("machine_phase: phase count must match the cycle layout");
  end

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  irq_gate_pkg::phase_state_t st;
  irq_gate_pkg::phase_state_t next_st;

  always_comb begin
    next_st = st;
    if (st.phase == irq_gate_pkg::PHASE_LAST) begin
      next_st.phase = 4'h0;
    end else begin
      next_st.phase = st.phase + 4'h1;
    end
    next_st.s5p2 = (next_st.phase == irq_gate_pkg::PHASE_S5P2);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.phase;
  assign s5p2  = st.s5p2;

endmodule

// ---- bench/core_model.sv ----
`timescale 1ns/1ps
module core_model (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    slow,
  input  wire logic [4:0]              irq_request,
  output irq_gate_pkg::core_ack_t      core_ack
);
  // ----------------------------------------------------------------
  // Polls requests and acknowledges each new one, lowest first
  // ----------------------------------------------------------------
  logic [4:0] seen;
  logic [3:0] cnt;
  logic [4:0] cand;
  logic [4:0] pick;

  assign cand = irq_request & ~seen;
  assign pick = cand & (~cand + 5'h01);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen     <= 5'h00;
      cnt      <= 4'h0;
      core_ack <= '0;
    end else begin
      core_ack <= '0;
      seen     <= seen & irq_request;
      if (pick == 5'h00) begin
        cnt <= 4'h0;
      end else if (cnt < (slow ? 4'h8 : 4'h1)) begin
        cnt <= cnt + 4'h1;
      end else begin
        core_ack <= '{valid: 1'b1, src: pick};
        seen     <= (seen & irq_request) | pick;
        cnt      <= 4'h0;
      end
    end
  end
endmodule

// ---- bench/interrupt_enable_gating_tb.sv ----
`timescale 1ns/1ps
module interrupt_enable_gating_tb;
  logic                    mclk;
  logic                    rst;
  logic [4:0]              address;
  logic                    read;
  logic                    write;
  logic [31:0]             writedata;
  logic [31:0]             readdata;
  logic                    waitrequest;
  logic                    pin_a_n;
  logic                    pin_b_n;
  logic                    tmr_a;
  logic                    tmr_b;
  logic                    ser;
  logic                    slow;
  logic [4:0]              irq_request;
  logic                    irq;
  logic [31:0]             rd;
  int                      n_errors;
  int                      n_tests;
  irq_gate_pkg::core_ack_t core_ack;

  irq_gate_top i_irq_gate_top (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ext_irq_pin_a_n(pin_a_n), .ext_irq_pin_b_n(pin_b_n),
    .timer_a_overflow(tmr_a), .timer_b_overflow(tmr_b), .serial_req(ser),
    .core_ack(core_ack), .irq_request(irq_request), .irq(irq));

  core_model i_core_model (
    .mclk(mclk), .rst(rst), .slow(slow), .irq_request(irq_request),
    .core_ack(core_ack));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic fire(input int i);
    @(posedge mclk);
    case (i)
      0: pin_a_n <= 1'b0;
      1: tmr_a <= 1'b1;
      2: pin_b_n <= 1'b0;
      3: tmr_b <= 1'b1;
      default: ser <= 1'b1;
    endcase
    @(posedge mclk);
    tmr_a <= 1'b0;
    tmr_b <= 1'b0;
    repeat (3) @(posedge mclk);
    pin_a_n <= 1'b1;
    pin_b_n <= 1'b1;
    ser     <= 1'b0;
  endtask

  task automatic wait_req(input logic [4:0] e);
    int n;
    n = 0;
    while (irq_request !== e && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("irq_request", {27'h0, e}, {27'h0, irq_request});
  endtask

  task automatic final_report;
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] p;
    bus(1'b0, irq_gate_pkg::OFF_PHASE, 32'h0);
    p = rd;
    chk("phase range", 32'h1, {31'h0, p < irq_gate_pkg::PHASES});
    rd_chk("phase step", irq_gate_pkg::OFF_PHASE, (p + 32'd3) % irq_gate_pkg::PHASES);
    rd_chk("enable", irq_gate_pkg::OFF_ENABLE, 32'h0);
    rd_chk("status", irq_gate_pkg::OFF_STATUS, 32'h0);
    rd_chk("mask", irq_gate_pkg::OFF_MASK, 32'h0);
    bus(1'b1, 5'h1c, 32'h9f);
    rd_chk("unmapped", 5'h1c, 32'h0);
    rd_chk("enable", irq_gate_pkg::OFF_ENABLE, 32'h0);
  endtask

  task automatic t_enable_bits;
    bus(1'b1, irq_gate_pkg::OFF_ENABLE, 32'h9f);
    bus(1'b1, irq_gate_pkg::OFF_EN_CLR, 32'h08);
    rd_chk("enable", irq_gate_pkg::OFF_ENABLE, 32'h97);
    bus(1'b1, irq_gate_pkg::OFF_EN_SET, 32'h08);
    rd_chk("enable", irq_gate_pkg::OFF_ENABLE, 32'h9f);
  endtask

  task automatic t_source(input int i);
    logic [4:0] b;
    b = 5'h01 << i;
    bus(1'b1, irq_gate_pkg::OFF_ENABLE, {24'h0, 3'h4, b});
    fire(i);
    if (i == 1 || i == 3) begin
      repeat (7) @(negedge mclk);
      chk("early request", 32'h0, {27'h0, irq_request});
    end
    wait_req(b);
    rd_chk("request reg", irq_gate_pkg::OFF_REQUEST, {27'h0, b});
    wait_req(5'h00);
    bus(1'b1, irq_gate_pkg::OFF_ENABLE, {24'h0, 3'h4, ~b});
    fire(i);
    repeat (30) @(negedge mclk);
    chk("blocked source", 32'h0, {27'h0, irq_request});
    rd_chk("status", irq_gate_pkg::OFF_STATUS, {27'h0, b});
    bus(1'b1, irq_gate_pkg::OFF_ENABLE, {24'h0, 3'h0, 5'h1f});
    repeat (30) @(negedge mclk);
    chk("global off", 32'h0, {27'h0, irq_request});
    bus(1'b1, irq_gate_pkg::OFF_EN_SET, 32'h80);
    wait_req(b);
    wait_req(5'h00);
  endtask

  task automatic t_irq_line;
    bus(1'b1, irq_gate_pkg::OFF_ENABLE, 32'h00);
    bus(1'b1, irq_gate_pkg::OFF_STATUS, 32'h1f);
    fire(4);
    repeat (4) @(negedge mclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    bus(1'b1, irq_gate_pkg::OFF_MASK, 32'h10);
    repeat (2) @(negedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, irq_gate_pkg::OFF_STATUS, 32'h10);
    repeat (2) @(negedge mclk);
    chk("cleared irq", 32'h0, {31'h0, irq});
    rd_chk("status", irq_gate_pkg::OFF_STATUS, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #100us;
    n_errors++;
    final_report();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    rst = 1'b1;
    {address, read, write, writedata} = '0;
    {pin_a_n, pin_b_n, tmr_a, tmr_b, ser, slow} = 6'b110000;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_enable_bits();
    for (int i = 0; i < 5; i++) begin
      slow <= (i >= 3);
      t_source(i);
    end
    t_irq_line();
    final_report();
  end
endmodule
